// ===== hw/amx_regs.sv
// Behaviour
// R1: bit 15 enables, bit 12 routes right dac
// R2: bit 11 routes left dac to aux b
// R3: bit 10 lowers aux b by 6 dB
// R4: bit 9 routes right record mixer
// R5: bit 2 stored, drives nothing
// R6: bit 1 routes right playback mixer
// R7: bit 0 routes left playback mixer
// R8: gain code 000 off, 001 -12 dB, +3/step
// R9: left play gain bits 11:9, third left
// R10: left play gain bits 7:5, right amp
// R11: left play gain bits 3:1, left amp
// R12: right play gain bits 15:13, third right
// R13: right play gain bits 7:5, right amp
// R14: right play gain bits 3:1, left amp
// R15: left rec gains bits 11:9 and 3:1
// R16: left rec bit 0 selects +20 dB boost
// R17: reset zero; unlisted bits read zero
// R18: written fields drive outputs next clock
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "amx_defines.svh"

module amx_regs (
    input  wire logic                    clock,
    input  wire logic                    reset_n,

    input  wire logic [11:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,

    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,

    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,

    input  wire logic [11:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,

    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,

    output logic                         aux_b_mixer_enable,
    output logic                         right_dac_to_aux_b,
    output logic                         left_dac_to_aux_b,
    output logic                         aux_b_minus6db,
    output logic                         right_rec_mix_to_aux_b,
    output logic                         right_play_mix_to_aux_b,
    output logic                         left_play_mix_to_aux_b,

    output logic [2:0]                   third_left_to_left_play_gain,
    output logic [2:0]                   right_amp_to_left_play_gain,
    output logic [2:0]                   left_amp_to_left_play_gain,
    output logic [2:0]                   third_right_to_right_play_gain,
    output logic [2:0]                   right_amp_to_right_play_gain,
    output logic [2:0]                   left_amp_to_right_play_gain,
    output logic [2:0]                   third_left_to_left_rec_gain,
    output logic [2:0]                   second_left_to_left_rec_gain,
    output logic                         left_amp_rec_boost,

    output logic [7:0]                   mix_path_on,
    output amx_pkg::amx_db_t [7:0]       mix_gain_db
);
    import amx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // {hit, select}; only aligned words of the four registers hit
    function automatic logic [2:0] decode_addr(input logic [11:0] addr);
        logic [2:0] result;

        result = 3'h0;

        if (addr[1:0] != 2'h0)
        begin
            result = 3'h0;
        end
        else if (addr[11:2] == {2'h0, `AMX_IDX_AUX_B})
        begin
            result = {1'b1, `AMX_SEL_AUX_B};
        end
        else if (addr[11:2] == {2'h0, `AMX_IDX_LEFT_PLAY})
        begin
            result = {1'b1, `AMX_SEL_LEFT_PLAY};
        end
        else if (addr[11:2] == {2'h0, `AMX_IDX_RIGHT_PLAY})
        begin
            result = {1'b1, `AMX_SEL_RIGHT_PLAY};
        end
        else if (addr[11:2] == {2'h0, `AMX_IDX_LEFT_REC})
        begin
            result = {1'b1, `AMX_SEL_LEFT_REC};
        end

        return result;
    endfunction

    // byte-lane merge; bits outside the mask stay zero
    function automatic logic [15:0] merge(
        input logic [15:0] old_value,
        input logic [15:0] new_value,
        input logic [1:0]  strb,
        input logic [15:0] mask
    );
        logic [15:0] lanes;

        lanes = {{8{strb[1]}}, {8{strb[0]}}};

        return ((new_value & lanes) | (old_value & ~lanes)) & mask; // [R17]
    endfunction

    // code to gain in dB; off codes report 0 and path_on low
    function automatic amx_db_t gain_db(input logic [2:0] code);
        logic [7:0] product;

        product = {5'h00, code} * `AMX_GAIN_STEP_DB;

        if (code == `AMX_GAIN_OFF)
        begin
            return 8'sh00;
        end

        return amx_db_t'(product - `AMX_GAIN_OFFSET_DB); // [R8]
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    amx_state_t state;
    amx_state_t next_state;

    logic [7:0][2:0] next_codes;

    logic        aw_take;
    logic        w_take;

    logic [11:0] wr_addr;
    logic [15:0] wr_data;
    logic [1:0]  wr_strb;

    logic [2:0]  wr_hit;
    logic [2:0]  rd_hit;

    assign aw_take = s_axi_awvalid && state.awready;
    assign w_take  = s_axi_wvalid && state.wready;

    assign wr_addr = state.aw_held ? state.awaddr : s_axi_awaddr;
    // upper lanes ignored; registers are 16 bits
    assign wr_data = state.w_held ? state.wdata : s_axi_wdata[15:0];
    assign wr_strb = state.w_held ? state.wstrb : s_axi_wstrb[1:0];

    assign wr_hit  = decode_addr(wr_addr);
    assign rd_hit  = decode_addr(s_axi_araddr);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_state = state;

        // write address and data may come in either order
        if (aw_take)
        begin
            next_state.aw_held = 1'b1;
            next_state.awaddr  = s_axi_awaddr;
        end
        if (w_take)
        begin
            next_state.w_held = 1'b1;
            next_state.wdata  = s_axi_wdata[15:0];
            next_state.wstrb  = s_axi_wstrb[1:0];
        end

        if (state.bvalid && s_axi_bready)
        begin
            next_state.bvalid = 1'b0;
        end

        // both halves present: write lands on this edge
        if ((state.aw_held || aw_take) && (state.w_held || w_take) && !state.bvalid)
        begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = wr_hit[2] ? `AMX_RESP_OKAY : `AMX_RESP_SLVERR;

            // a miss stores nothing and answers slverr
            if (wr_hit[2])
            begin
                case (wr_hit[1:0])
                    `AMX_SEL_AUX_B:
                        next_state.aux_b = merge(state.aux_b, wr_data, wr_strb,
                                                 `AMX_MASK_AUX_B);

                    `AMX_SEL_LEFT_PLAY:
                        next_state.left_play = merge(state.left_play, wr_data, wr_strb,
                                                     `AMX_MASK_LEFT_PLAY);

                    `AMX_SEL_RIGHT_PLAY:
                        next_state.right_play = merge(state.right_play, wr_data, wr_strb,
                                                      `AMX_MASK_RIGHT_PLAY);

                    default:
                        next_state.left_rec = merge(state.left_rec, wr_data, wr_strb,
                                                    `AMX_MASK_LEFT_REC);
                endcase
            end
        end

        // one write in flight; ready drops while a half is held
        next_state.awready = !next_state.aw_held && !next_state.bvalid;
        next_state.wready  = !next_state.w_held && !next_state.bvalid;

        // reads: one at a time, answered on the edge after the address
        if (state.rvalid && s_axi_rready)
        begin
            next_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state.arready)
        begin
            next_state.rvalid = 1'b1;
            next_state.rresp  = rd_hit[2] ? `AMX_RESP_OKAY : `AMX_RESP_SLVERR;
            next_state.rdata  = `AMX_RESET_VALUE;

            if (rd_hit[2])
            begin
                case (rd_hit[1:0])
                    `AMX_SEL_AUX_B:
                        next_state.rdata = state.aux_b;
                    `AMX_SEL_LEFT_PLAY:
                        next_state.rdata = state.left_play;
                    `AMX_SEL_RIGHT_PLAY:
                        next_state.rdata = state.right_play;
                    default:
                        next_state.rdata = state.left_rec;
                endcase
            end
        end

        next_state.arready = !next_state.rvalid;

        // gain codes as the registers will hold them after this edge
        next_codes[0] = next_state.left_play[`AMX_F_UP];   // [R9]
        next_codes[1] = next_state.left_play[`AMX_F_MID];  // [R10]
        next_codes[2] = next_state.left_play[`AMX_F_LO];   // [R11]
        next_codes[3] = next_state.right_play[`AMX_F_HI];  // [R12]
        next_codes[4] = next_state.right_play[`AMX_F_MID]; // [R13]
        next_codes[5] = next_state.right_play[`AMX_F_LO];  // [R14]
        next_codes[6] = next_state.left_rec[`AMX_F_UP];    // [R15]
        next_codes[7] = next_state.left_rec[`AMX_F_LO];    // [R15]

        // decoded gains follow the codes on the same edge
        for (int i = 0; i < `AMX_NUM_GAINS; i++)
        begin
            next_state.path_on[i] = (next_codes[i] != `AMX_GAIN_OFF); // [R8]
            next_state.gain_db[i] = gain_db(next_codes[i]);           // [R8]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state            <= '0;

            state.aux_b      <= `AMX_RESET_VALUE; // [R17]
            state.left_play  <= `AMX_RESET_VALUE; // [R17]
            state.right_play <= `AMX_RESET_VALUE; // [R17]
            state.left_rec   <= `AMX_RESET_VALUE; // [R17]

            // bus idle and ready straight out of reset
            state.awready    <= 1'b1;
            state.wready     <= 1'b1;
            state.arready    <= 1'b1;
        end
        else
        begin
            state <= next_state; // [R18]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus outputs

    assign s_axi_awready = state.awready;
    assign s_axi_wready  = state.wready;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;

    assign s_axi_arready = state.arready;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rresp   = state.rresp;
    assign s_axi_rdata   = {16'h0000, state.rdata};

    ////////////////////////////////////////////////////////////////////////////
    // analogue control lines, straight from the register flops

    assign aux_b_mixer_enable      = state.aux_b[`AMX_B_ENABLE];     // [R1]
    assign right_dac_to_aux_b      = state.aux_b[`AMX_B_RIGHT_DAC];  // [R1]
    assign left_dac_to_aux_b       = state.aux_b[`AMX_B_LEFT_DAC];   // [R2]
    assign aux_b_minus6db          = state.aux_b[`AMX_B_MINUS6DB];   // [R3]
    assign right_rec_mix_to_aux_b  = state.aux_b[`AMX_B_RIGHT_REC];  // [R4]
    // aux a bit is kept for read-back only; the route is not built [R5]
    assign right_play_mix_to_aux_b = state.aux_b[`AMX_B_RIGHT_PLAY]; // [R6]
    assign left_play_mix_to_aux_b  = state.aux_b[`AMX_B_LEFT_PLAY];  // [R7]

    assign third_left_to_left_play_gain   = state.left_play[`AMX_F_UP];   // [R9]
    assign right_amp_to_left_play_gain    = state.left_play[`AMX_F_MID];  // [R10]
    assign left_amp_to_left_play_gain     = state.left_play[`AMX_F_LO];   // [R11]

    assign third_right_to_right_play_gain = state.right_play[`AMX_F_HI];  // [R12]
    assign right_amp_to_right_play_gain   = state.right_play[`AMX_F_MID]; // [R13]
    assign left_amp_to_right_play_gain    = state.right_play[`AMX_F_LO];  // [R14]

    assign third_left_to_left_rec_gain    = state.left_rec[`AMX_F_UP];    // [R15]
    assign second_left_to_left_rec_gain   = state.left_rec[`AMX_F_LO];    // [R15]
    assign left_amp_rec_boost             = state.left_rec[`AMX_F_BOOST]; // [R16]

    // mixers see one decoded word per path, not raw codes
    assign mix_path_on = state.path_on;

    genvar g;

    generate
        for (g = 0; g < `AMX_NUM_GAINS; g++)
        begin : g_gain
            assign mix_gain_db[g] = amx_db_t'(state.gain_db[g]);
        end
    endgenerate

endmodule

// ===== hw/amx_defines.svh
`ifndef AMX_DEFINES_SVH
`define AMX_DEFINES_SVH

// register indices as printed; byte address is four times the index
`define AMX_IDX_AUX_B        8'h5d
`define AMX_IDX_LEFT_PLAY    8'h60
`define AMX_IDX_RIGHT_PLAY   8'h61
`define AMX_IDX_LEFT_REC     8'h62
`define AMX_ADDR_W           12
`define AMX_REG_W            16

// register select codes
`define AMX_SEL_AUX_B        2'h0
`define AMX_SEL_LEFT_PLAY    2'h1
`define AMX_SEL_RIGHT_PLAY   2'h2
`define AMX_SEL_LEFT_REC     2'h3

// aux output b control fields
`define AMX_B_ENABLE         15
`define AMX_B_RIGHT_DAC      12
`define AMX_B_LEFT_DAC       11
`define AMX_B_MINUS6DB       10
`define AMX_B_RIGHT_REC      9
`define AMX_B_AUX_A          2
`define AMX_B_RIGHT_PLAY     1
`define AMX_B_LEFT_PLAY      0

// gain code fields
`define AMX_F_HI             15:13
`define AMX_F_UP             11:9
`define AMX_F_MID            7:5
`define AMX_F_LO             3:1
`define AMX_F_BOOST          0

// writable bits; others read zero
`define AMX_MASK_AUX_B       16'h9e07
`define AMX_MASK_LEFT_PLAY   16'h0eee
`define AMX_MASK_RIGHT_PLAY  16'he0ee
`define AMX_MASK_LEFT_REC    16'h0e0f
`define AMX_RESET_VALUE      16'h0000

// gain decode: 001 = -12 dB, +3 dB a step
`define AMX_GAIN_OFF         3'h0
`define AMX_GAIN_STEP_DB     8'h03
`define AMX_GAIN_OFFSET_DB   8'h0f
`define AMX_NUM_GAINS        8

// axi responses
`define AMX_RESP_OKAY        2'h0
`define AMX_RESP_SLVERR      2'h2

`endif

// ===== hw/amx_pkg.sv
package amx_pkg;

    typedef logic signed [7:0] amx_db_t;

    typedef struct packed {
        logic                  aw_held;
        logic                  w_held;
        logic [11:0]           awaddr;
        logic [15:0]           wdata;
        logic [1:0]            wstrb;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [15:0]           rdata;
        logic [15:0]           aux_b;
        logic [15:0]           left_play;
        logic [15:0]           right_play;
        logic [15:0]           left_rec;
        logic [7:0]            path_on;
        logic [7:0][7:0]       gain_db;
    } amx_state_t;

endpackage

// ===== verif/amx_regs_sva.sv
`timescale 1ns/10ps
module amx_regs_sva
    import amx_pkg::*;
(
    input wire logic                 clock,
    input wire logic                 reset_n,
    input wire logic [11:0]          s_axi_awaddr,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic [31:0]          s_axi_wdata,
    input wire logic [3:0]           s_axi_wstrb,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic [1:0]           s_axi_bresp,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic                 aux_b_mixer_enable,
    input wire logic [2:0]           third_left_to_left_play_gain,
    input wire logic [2:0]           right_amp_to_left_play_gain,
    input wire logic [2:0]           left_amp_to_left_play_gain,
    input wire logic [2:0]           third_right_to_right_play_gain,
    input wire logic [2:0]           right_amp_to_right_play_gain,
    input wire logic [2:0]           left_amp_to_right_play_gain,
    input wire logic [2:0]           third_left_to_left_rec_gain,
    input wire logic [2:0]           second_left_to_left_rec_gain,
    input wire logic [7:0]           mix_path_on,
    input wire amx_pkg::amx_db_t [7:0] mix_gain_db
);
    import amx_pkg::*;
    logic [7:0][2:0] code;
    amx_db_t [7:0]   db_exp;
    logic [7:0]      on_exp;
    logic [11:0]     wr_addr;
    logic [15:0]     wr_data;
    logic            wr_hi;
    assign code = {second_left_to_left_rec_gain, third_left_to_left_rec_gain,
                   left_amp_to_right_play_gain, right_amp_to_right_play_gain,
                   third_right_to_right_play_gain, left_amp_to_left_play_gain,
                   right_amp_to_left_play_gain, third_left_to_left_play_gain};
    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            on_exp[i] = code[i] != 3'h0;
            db_exp[i] = on_exp[i] ? amx_db_t'({5'h00, code[i] - 3'h1} * 8'h03 - 8'h0c) : 8'h00;
        end
    end
    // halves may arrive in either order, so latch each as taken
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_addr <= 12'h000;
            wr_data <= 16'h0000;
            wr_hi   <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                wr_addr <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
            begin
                wr_data <= s_axi_wdata[15:0];
                wr_hi   <= s_axi_wstrb[1];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    sequence s_wr_pair;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_done;
        $rose(s_axi_bvalid) && s_axi_bresp == 2'h0;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_answer;
        s_wr_pair |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_b_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_r_upper;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    property p_decode;
        mix_path_on == on_exp && mix_gain_db == db_exp;
    endproperty
    property p_field_next;
        s_wr_done ##0 (wr_addr == 12'h174 && wr_hi) |-> aux_b_mixer_enable == wr_data[15];
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write pair not answered next edge");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    a_b_busy: assert property (p_b_busy)
        else $error("write ready while response pending");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered next edge");
    a_r_hold: assert property (p_r_hold)
        else $error("read data changed while waiting");
    a_r_upper: assert property (p_r_upper)
        else $error("read upper half not zero");
    a_decode: assert property (p_decode)
        else $error("gain decode mismatch");
    a_field_next: assert property (p_field_next)
        else $error("enable output not updated with write");
endmodule

// ===== verif/amx_regs_tb.sv
`timescale 1ns/10ps
`include "amx_defines.svh"
module amx_regs_tb;
    import amx_pkg::*;
    logic          clock, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic          s_axi_rready, aux_b_mixer_enable, right_dac_to_aux_b, left_dac_to_aux_b;
    logic          aux_b_minus6db, right_rec_mix_to_aux_b, right_play_mix_to_aux_b;
    logic          left_play_mix_to_aux_b, left_amp_rec_boost;
    logic [11:0]   s_axi_awaddr, s_axi_araddr;
    logic [31:0]   s_axi_wdata, s_axi_rdata, got;
    logic [3:0]    s_axi_wstrb;
    logic [1:0]    s_axi_bresp, s_axi_rresp, resp;
    logic [2:0]    third_left_to_left_play_gain, right_amp_to_left_play_gain;
    logic [2:0]    left_amp_to_left_play_gain, third_right_to_right_play_gain;
    logic [2:0]    right_amp_to_right_play_gain, left_amp_to_right_play_gain;
    logic [2:0]    third_left_to_left_rec_gain, second_left_to_left_rec_gain, c;
    logic [7:0]    mix_path_on, e;
    amx_db_t [7:0] mix_gain_db;
    logic [6:0]    flags;
    logic [23:0]   gains;
    logic [15:0]   v;
    int            err_total, check_count;
    logic [7:0]    idx [4] = '{`AMX_IDX_AUX_B, `AMX_IDX_LEFT_PLAY, `AMX_IDX_RIGHT_PLAY,
                               `AMX_IDX_LEFT_REC};
    logic [15:0]   msk [4] = '{16'h9e07, 16'h0eee, 16'he0ee, 16'h0e0f};
    int            bitpos [7] = '{15, 12, 11, 10, 9, 1, 0};
    assign flags = {aux_b_mixer_enable, right_dac_to_aux_b, left_dac_to_aux_b, aux_b_minus6db,
                    right_rec_mix_to_aux_b, right_play_mix_to_aux_b, left_play_mix_to_aux_b};
    assign gains = {second_left_to_left_rec_gain, third_left_to_left_rec_gain,
                    left_amp_to_right_play_gain, right_amp_to_right_play_gain,
                    third_right_to_right_play_gain, left_amp_to_left_play_gain,
                    right_amp_to_left_play_gain, third_left_to_left_play_gain};
    amx_regs u_amx_regs (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .aux_b_mixer_enable, .right_dac_to_aux_b,
        .left_dac_to_aux_b, .aux_b_minus6db, .right_rec_mix_to_aux_b, .right_play_mix_to_aux_b,
        .left_play_mix_to_aux_b, .third_left_to_left_play_gain, .right_amp_to_left_play_gain,
        .left_amp_to_left_play_gain, .third_right_to_right_play_gain,
        .right_amp_to_right_play_gain, .left_amp_to_right_play_gain,
        .third_left_to_left_rec_gain, .second_left_to_left_rec_gain, .left_amp_rec_boost,
        .mix_path_on, .mix_gain_db);
    always #4 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // ready sampled at the falling edge, so release lands right after the taking edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d,
                       input logic [3:0] s, input logic [1:0] er);
        logic ta, tw, tr, fin;
        if (w)
        begin
            s_axi_awaddr  <= a;
            s_axi_wdata   <= {16'h0000, d};
            s_axi_wstrb   <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
        end
        else
        begin
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
        end
        for (int n = 0; n < 40; n++)
        begin
            @(negedge clock);
            ta   = s_axi_awvalid && s_axi_awready === 1'b1;
            tw   = s_axi_wvalid && s_axi_wready === 1'b1;
            tr   = s_axi_arvalid && s_axi_arready === 1'b1;
            fin  = w ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1;
            resp = w ? s_axi_bresp : s_axi_rresp;
            got  = s_axi_rdata;
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_arvalid <= 1'b0;
            if (fin)
            begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                check({30'h0, resp}, {30'h0, er});
                @(posedge clock);
                return;
            end
        end
        err_total++;
        tally_and_finish();
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] x, input logic [1:0] er);
        bus(1'b0, a, 16'h0000, 4'h0, er);
        check(got, {16'h0000, x});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        reset_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        for (int k = 0; k < 4; k++)
            rd({2'h0, idx[k], 2'h0}, 16'h0000, 2'h0);
        check({flags, gains, left_amp_rec_boost}, 32'h0);
        $display("reset values done");
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, {2'h0, idx[k], 2'h0}, 16'hffff, 4'hf, 2'h0);
            rd({2'h0, idx[k], 2'h0}, msk[k], 2'h0);
        end
        bus(1'b1, 12'h188, 16'h0000, 4'h2, 2'h0);
        rd(12'h188, 16'h000f, 2'h0);
        $display("masks and lanes done");
        for (int k = 0; k < 7; k++)
        begin
            v = 16'h0001 << bitpos[k];
            bus(1'b1, 12'h174, v, 4'h3, 2'h0);
            check({25'h0, flags}, 32'h1 << (6 - k));
        end
        bus(1'b1, 12'h174, 16'h0004, 4'h3, 2'h0);
        check({25'h0, flags}, 32'h0);
        rd(12'h174, 16'h0004, 2'h0);
        $display("route bits done");
        for (int k = 0; k < 8; k++)
        begin
            c = 3'(k);
            e = (k == 0) ? 8'h00 : 8'(k * 3 - 15);
            bus(1'b1, 12'h180, {4'h0, c, 1'b0, c, 1'b0, c, 1'b0}, 4'h3, 2'h0);
            bus(1'b1, 12'h184, {c, 5'h00, c, 1'b0, c, 1'b0}, 4'h3, 2'h0);
            bus(1'b1, 12'h188, {4'h0, c, 5'h00, c, c[0]}, 4'h3, 2'h0);
            check({8'h0, gains}, {8'h0, {8{c}}});
            check({31'h0, left_amp_rec_boost}, {31'h0, c[0]});
            check({24'h0, mix_path_on}, {24'h0, {8{c != 3'h0}}});
            check({16'h0, mix_gain_db[7], mix_gain_db[0]}, {16'h0, e, e});
        end
        $display("gain codes done");
        bus(1'b1, 12'h175, 16'hffff, 4'hf, 2'h2);
        bus(1'b1, 12'h178, 16'hffff, 4'hf, 2'h2);
        rd(12'h178, 16'h0000, 2'h2);
        rd(12'h174, 16'h0004, 2'h0);
        $display("unmapped access done");
        reset_n <= 1'b0;
        @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rd(12'h184, 16'h0000, 2'h0);
        check({flags, gains, left_amp_rec_boost}, 32'h0);
        $display("second reset done");
        tally_and_finish();
    end
endmodule
////////////////////////////////////////////////////////////////////////////////
bind amx_regs amx_regs_sva u_amx_regs_sva (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .aux_b_mixer_enable, .third_left_to_left_play_gain,
    .right_amp_to_left_play_gain, .left_amp_to_left_play_gain, .third_right_to_right_play_gain,
    .right_amp_to_right_play_gain, .left_amp_to_right_play_gain, .third_left_to_left_rec_gain,
    .second_left_to_left_rec_gain, .mix_path_on, .mix_gain_db);
